/* rtl/vam_pkg.sv */
// constants, alert map and carrier types for the valve alert monitor
package vam_pkg;
    // clock and drive-signal persistence
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned DRV_PERSIST_S = 20;
    localparam int unsigned DRV_PERSIST_CYC = DRV_PERSIST_S * CLK_HZ;
    // alert record depth
    localparam int unsigned REC_DEPTH = 20;
    // drive and travel thresholds, percent
    localparam logic [7:0] DRV_LO_PCT = 8'h0a;
    localparam logic [7:0] DRV_HI_PCT = 8'h5a;
    localparam logic [7:0] TRV_LO_PCT = 8'h03;
    localparam logic [7:0] TRV_HI_PCT = 8'h61;
    // host command number that returns active alerts
    localparam logic [7:0] CMD_READ_STATUS = 8'h30;
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ALERT_EN = 8'h04;
    localparam logic [7:0] OFS_SHUT_EN = 8'h08;
    localparam logic [7:0] OFS_CYC_CNT = 8'h0c;
    localparam logic [7:0] OFS_CYC_PT = 8'h10;
    localparam logic [7:0] OFS_ACTIVE = 8'h14;
    localparam logic [7:0] OFS_REC_STAT = 8'h18;
    localparam logic [7:0] OFS_REC_IDX = 8'h1c;
    localparam logic [7:0] OFS_REC_DATA = 8'h20;
    localparam logic [7:0] OFS_DEV_ALLOW = 8'h24;
    // control register bit positions
    localparam int CTRL_ZP_OPEN = 0;
    localparam int CTRL_PANEL_MODE = 1;
    localparam int CTRL_REC_CLEAR = 2;
    localparam int CTRL_TIME_SET = 3;
    // alert bit positions
    localparam int AL_FLASH = 0;
    localparam int AL_CRIT_NVM = 4;
    localparam int AL_REC_NOT_EMPTY = 8;
    localparam int AL_REC_FULL = 9;
    localparam int AL_CAL = 10;
    localparam int AL_AUTOCAL = 11;
    localparam int AL_DIAG = 12;
    localparam int AL_DIAG_DATA = 13;
    localparam int AL_CYC_HIGH = 14;
    localparam int AL_TIME_APPROX = 15;
    localparam int AL_INTEG_HI = 16;
    localparam int AL_INTEG_LO = 17;
    localparam int AL_PANEL_COMM = 18;
    localparam int AL_STUCK_BTN = 19;
    localparam int AL_EP_DEV = 20;
    localparam int AL_LOOP_CUR = 21;
    localparam int AL_DRIVE_SIG = 22;
    // factory defaults and fixed masks
    localparam logic [31:0] EN_RESET = 32'h007c00ff;
    localparam logic [31:0] SHUT_RESET = 32'h00000000;
    localparam logic [31:0] FIXED_MASK = 32'h000000ff;
    localparam logic [31:0] SHUT_AVAIL = 32'h000000ff;
    localparam logic [31:0] FAIL_MASK = 32'h002c00ff;
    localparam logic [31:0] REC_EXCL = 32'h00000300;
    localparam logic [15:0] CYC_PT_RESET = 16'hffff;
    localparam logic [15:0] DEV_ALLOW_RESET = 16'h0100;

    // classic wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } vam_wb_req_t;

    // sensed conditions from the rest of the controller
    typedef struct packed {
        logic [7:0] hw_fault;
        logic loop_bad;
        logic cal;
        logic autocal;
        logic diag;
        logic diag_data;
        logic integ_hi;
        logic integ_lo;
        logic panel_link_ok;
        logic button_held;
        logic press_ctrl;
        logic reversal;
        logic [7:0] drive_pct;
        logic [7:0] travel_pct;
        logic [15:0] press;
        logic [15:0] press_sp;
    } vam_sense_t;
endpackage : vam_pkg

/* rtl/vam_top.sv */
// alert detection, alert record and host status reporting
`timescale 1ns/1ps
module vam_top #(
    parameter int unsigned DRV_PERSIST_CYC_P = vam_pkg::DRV_PERSIST_CYC,
    parameter logic [23:0] DEVICE_ID = 24'h5a5a5a // arbitrary value
) (
    input wire logic i_ref_clk, // 20 MHz clock
    input wire logic i_sys_rst, // sync reset, high
    input wire vam_pkg::vam_wb_req_t i_wb, // wishbone request
    output logic o_wb_ack, // wishbone ack
    output logic [31:0] o_wb_dat, // wishbone read data
    input wire vam_pkg::vam_sense_t i_sense, // sensed conditions
    input wire logic i_cmd_valid, // host command strobe
    input wire logic [23:0] i_cmd_addr, // addressed device id
    input wire logic [7:0] i_cmd_num, // command number
    output logic o_rsp_valid, // status answer strobe
    output logic [31:0] o_rsp_status, // reported alerts
    output logic o_shutdown, // shutdown demand
    output logic o_failure_any // failure category active
);
    import vam_pkg::*;

    logic [31:0] alert_en;
    logic [31:0] shut_en;
    logic [31:0] active;
    logic [31:0] reported;
    logic [31:0] prev_rep;
    logic [31:0] pend;
    logic [31:0] next_pend;
    logic [4:0] rec_mem [REC_DEPTH];
    logic [4:0] rec_cnt;
    logic [4:0] rec_idx;
    logic [4:0] pick;
    logic pick_ok;
    logic rec_full;
    logic zp_open;
    logic panel_mode;
    logic [15:0] cyc_cnt;
    logic [15:0] cyc_pt;
    logic [15:0] dev_allow;
    logic cyc_high;
    logic time_approx;
    logic flash_lat;
    logic nvm_lat;
    logic loop_lat;
    logic [31:0] drv_cnt;
    logic drv_cond;
    logic drv_alert;
    logic [15:0] press_err;
    logic wr;
    logic rd;
    logic [31:0] next_rdat;

    // bus access on the cycle the ack is raised
    assign wr = i_wb.cyc && i_wb.stb && i_wb.we && !o_wb_ack;
    assign rd = i_wb.cyc && i_wb.stb && !i_wb.we && !o_wb_ack;

    // byte-lane merge of write data
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction : lane_merge

    // byte-lane merge for the 16-bit registers
    function automatic logic [15:0] lane_merge16(input logic [15:0] old,
                                                 input logic [15:0] nw,
                                                 input logic [1:0] sel);
        return {sel[1] ? nw[15:8] : old[15:8],
                sel[0] ? nw[7:0] : old[7:0]};
    endfunction : lane_merge16

    // single wait-state ack, dropped the cycle after
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            o_wb_ack <= 1'b0;
        else
            o_wb_ack <= i_wb.cyc && i_wb.stb && !o_wb_ack;
    end

    // control bits and configuration registers
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            zp_open <= 1'b0;
            panel_mode <= 1'b0;
            alert_en <= EN_RESET;
            shut_en <= SHUT_RESET;
            cyc_pt <= CYC_PT_RESET;
            dev_allow <= DEV_ALLOW_RESET;
            rec_idx <= 5'h00;
        end
        else if (wr)
        begin
            case (i_wb.adr)
                OFS_CTRL:
                begin
                    if (i_wb.sel[0])
                    begin
                        zp_open <= i_wb.dat[CTRL_ZP_OPEN];
                        panel_mode <= i_wb.dat[CTRL_PANEL_MODE];
                    end
                end
                OFS_ALERT_EN:
                begin
                    // fixed alerts keep their factory enable
                    alert_en <= (lane_merge(alert_en, i_wb.dat, i_wb.sel)
                                 & ~FIXED_MASK)
                              | (EN_RESET & FIXED_MASK);
                end
                OFS_SHUT_EN:
                    shut_en <= lane_merge(shut_en, i_wb.dat, i_wb.sel)
                             & SHUT_AVAIL;
                OFS_CYC_PT:
                    cyc_pt <= lane_merge16(cyc_pt, i_wb.dat[15:0],
                                           i_wb.sel[1:0]);
                OFS_DEV_ALLOW:
                    dev_allow <= lane_merge16(dev_allow, i_wb.dat[15:0],
                                              i_wb.sel[1:0]);
                OFS_REC_IDX:
                    if (i_wb.sel[0])
                        rec_idx <= i_wb.dat[4:0];
                default:
                    rec_idx <= rec_idx;
            endcase
        end
    end

    // reversal counter, host may overwrite it
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            cyc_cnt <= 16'h0000;
        else if (wr && i_wb.adr == OFS_CYC_CNT)
            cyc_cnt <= lane_merge16(cyc_cnt, i_wb.dat[15:0],
                                    i_wb.sel[1:0]);
        else if (i_sense.reversal && cyc_cnt != 16'hffff)
            cyc_cnt <= cyc_cnt + 16'h0001;
    end

    // cycle alert: set above point, cleared only by a low write
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            cyc_high <= 1'b0;
        else if (cyc_cnt > cyc_pt && !(wr && i_wb.adr == OFS_CYC_CNT))
            cyc_high <= 1'b1;
        else if (wr && i_wb.adr == OFS_CYC_CNT
                 && lane_merge16(cyc_cnt, i_wb.dat[15:0],
                                 i_wb.sel[1:0]) < cyc_pt)
            cyc_high <= 1'b0;
    end

    // time approximate after power-up until clock is set
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            time_approx <= 1'b1;
        else if (wr && i_wb.adr == OFS_CTRL && i_wb.sel[0]
                 && i_wb.dat[CTRL_TIME_SET])
            time_approx <= 1'b0;
    end

    // restart-only latches for memory and loop faults
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            flash_lat <= 1'b0;
            nvm_lat <= 1'b0;
            loop_lat <= 1'b0;
        end
        else
        begin
            flash_lat <= flash_lat | i_sense.hw_fault[AL_FLASH];
            nvm_lat <= nvm_lat | i_sense.hw_fault[AL_CRIT_NVM];
            loop_lat <= loop_lat | i_sense.loop_bad;
        end
    end

    // drive against travel mismatch for either zero-power setting
    always_comb
    begin
        if (zp_open)
            drv_cond = (i_sense.drive_pct < DRV_LO_PCT
                        && i_sense.travel_pct < TRV_HI_PCT)
                    || (i_sense.drive_pct > DRV_HI_PCT
                        && i_sense.travel_pct > TRV_LO_PCT);
        else
            drv_cond = (i_sense.drive_pct < DRV_LO_PCT
                        && i_sense.travel_pct > TRV_LO_PCT)
                    || (i_sense.drive_pct > DRV_HI_PCT
                        && i_sense.travel_pct < TRV_HI_PCT);
    end

    // persistence timer, saturates once the time has passed
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            drv_cnt <= 32'h00000000;
        else if (!drv_cond)
            drv_cnt <= 32'h00000000;
        else if (drv_cnt != DRV_PERSIST_CYC_P)
            drv_cnt <= drv_cnt + 32'h00000001;
    end
    assign drv_alert = drv_cond && drv_cnt == DRV_PERSIST_CYC_P;

    // pressure tracking error magnitude
    assign press_err = (i_sense.press > i_sense.press_sp)
                     ? i_sense.press - i_sense.press_sp
                     : i_sense.press_sp - i_sense.press;

    // active alert vector
    always_comb
    begin
        active = 32'h00000000;
        active[7:0] = i_sense.hw_fault;
        active[AL_FLASH] = flash_lat;
        active[AL_CRIT_NVM] = nvm_lat;
        active[AL_REC_NOT_EMPTY] = rec_cnt != 5'h00;
        active[AL_REC_FULL] = rec_full;
        active[AL_CAL] = i_sense.cal;
        active[AL_AUTOCAL] = i_sense.autocal;
        active[AL_DIAG] = i_sense.diag;
        active[AL_DIAG_DATA] = i_sense.diag_data;
        active[AL_CYC_HIGH] = cyc_high;
        active[AL_TIME_APPROX] = time_approx;
        active[AL_INTEG_HI] = i_sense.integ_hi;
        active[AL_INTEG_LO] = i_sense.integ_lo;
        active[AL_PANEL_COMM] = panel_mode && !i_sense.panel_link_ok;
        active[AL_STUCK_BTN] = i_sense.button_held;
        active[AL_EP_DEV] = i_sense.press_ctrl && press_err > dev_allow;
        active[AL_LOOP_CUR] = loop_lat;
        active[AL_DRIVE_SIG] = drv_alert;
    end
    assign reported = active & alert_en;
    assign rec_full = rec_cnt == 5'(REC_DEPTH);

    // lowest pending new alert to store
    always_comb
    begin
        pick = 5'h00;
        pick_ok = 1'b0;
        for (int i = 31; i >= 0; i--)
        begin
            if (pend[i])
            begin
                pick = 5'(i);
                pick_ok = 1'b1;
            end
        end
        next_pend = pend | (reported & ~prev_rep & ~REC_EXCL);
        if (pick_ok)
            next_pend[pick] = 1'b0;
    end

    // alert record fill and clear
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            rec_cnt <= 5'h00;
            pend <= 32'h00000000;
            prev_rep <= 32'h00000000;
        end
        else
        begin
            prev_rep <= reported;
            if (wr && i_wb.adr == OFS_CTRL && i_wb.sel[0]
                && i_wb.dat[CTRL_REC_CLEAR])
            begin
                rec_cnt <= 5'h00;
                pend <= 32'h00000000;
            end
            else if (rec_full)
                pend <= 32'h00000000;
            else
            begin
                pend <= next_pend;
                if (pick_ok)
                begin
                    rec_mem[rec_cnt] <= pick;
                    rec_cnt <= rec_cnt + 5'h01;
                end
            end
        end
    end

    // register read mux, unmapped reads as zero
    always_comb
    begin
        next_rdat = 32'h00000000;
        case (i_wb.adr)
            OFS_CTRL:
                next_rdat = {28'h0000000, 2'b00, panel_mode, zp_open};
            OFS_ALERT_EN:
                next_rdat = alert_en;
            OFS_SHUT_EN:
                next_rdat = shut_en;
            OFS_CYC_CNT:
                next_rdat = {16'h0000, cyc_cnt};
            OFS_CYC_PT:
                next_rdat = {16'h0000, cyc_pt};
            OFS_ACTIVE:
                next_rdat = reported;
            OFS_REC_STAT:
                next_rdat = {25'h0000000, rec_full, rec_cnt != 5'h00,
                             rec_cnt};
            OFS_REC_IDX:
                next_rdat = {27'h0000000, rec_idx};
            OFS_REC_DATA:
                next_rdat = (rec_idx < rec_cnt)
                          ? {27'h0000000, rec_mem[rec_idx]} : 32'h00000000;
            OFS_DEV_ALLOW:
                next_rdat = {16'h0000, dev_allow};
            default:
                next_rdat = 32'h00000000;
        endcase
    end

    // read data register
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            o_wb_dat <= 32'h00000000;
        else if (rd)
            o_wb_dat <= next_rdat;
    end

    // host status command answer
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_rsp_valid <= 1'b0;
            o_rsp_status <= 32'h00000000;
        end
        else
        begin
            o_rsp_valid <= i_cmd_valid && i_cmd_addr == DEVICE_ID
                        && i_cmd_num == CMD_READ_STATUS;
            if (i_cmd_valid && i_cmd_addr == DEVICE_ID
                && i_cmd_num == CMD_READ_STATUS)
                o_rsp_status <= reported;
        end
    end

    // shutdown and failure summaries
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_shutdown <= 1'b0;
            o_failure_any <= 1'b0;
        end
        else
        begin
            o_shutdown <= |(reported & shut_en & SHUT_AVAIL);
            o_failure_any <= |(reported & FAIL_MASK);
        end
    end

    a_rec_bound: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        rec_cnt <= 5'(REC_DEPTH))
        else $error("record count above depth");
    a_rec_full_hold: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        rec_full && !wr |=> rec_cnt == $past(rec_cnt))
        else $error("full record grew");
    a_full_flag: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        rec_cnt == 5'(REC_DEPTH - 1) && pick_ok && !wr
        |=> active[AL_REC_FULL])
        else $error("full flag wrong");
    a_not_empty: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        pick_ok && !rec_full && !wr |=> active[AL_REC_NOT_EMPTY])
        else $error("not-empty flag missing");
    a_rsp_answer: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        i_cmd_valid && i_cmd_num == CMD_READ_STATUS
        && i_cmd_addr == DEVICE_ID
        |=> o_rsp_valid && o_rsp_status == $past(reported))
        else $error("status command unanswered");
    a_id_filter: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        i_cmd_valid && i_cmd_addr != DEVICE_ID |=> !o_rsp_valid)
        else $error("foreign command answered");
    a_fixed_en: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (alert_en & FIXED_MASK) == (EN_RESET & FIXED_MASK))
        else $error("fixed enable changed");
    a_cyc_sticky: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        cyc_high && !(wr && i_wb.adr == OFS_CYC_CNT) |=> cyc_high)
        else $error("cycle alert cleared without write");
    a_drv_persist: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        $rose(drv_alert) |-> $past(drv_cond, 2))
        else $error("drive alert without persistence");
    a_nvm_latch: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        nvm_lat && flash_lat |=> nvm_lat && flash_lat)
        else $error("memory latch dropped");
    a_loop_latch: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        i_sense.loop_bad |=> active[AL_LOOP_CUR] [*2])
        else $error("loop alert not held");
    a_shut_gate: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        (reported & shut_en) == 32'h00000000 |=> !o_shutdown)
        else $error("shutdown without enable");
endmodule : vam_top

/* bench/vam_host_model.sv */
// host-side model issuing addressed status commands
`timescale 1ns/1ps
module vam_host_model (
    input wire logic i_clk, // bench clock
    input wire logic i_rst, // sync reset, high
    input wire logic i_go, // issue one command
    input wire logic [23:0] i_adr, // target device id
    input wire logic [7:0] i_num, // command number
    output logic o_cmd_valid, // one-cycle command strobe
    output logic [23:0] o_cmd_addr, // addressed id
    output logic [7:0] o_cmd_num // command number
);
    // one-cycle strobe; fields scramble outside it
    always_ff @(posedge i_clk)
    begin
        o_cmd_valid <= i_go & ~i_rst;
        if (i_rst)
        begin
            o_cmd_addr <= 24'h0;
            o_cmd_num <= 8'h0;
        end
        else if (i_go)
        begin
            o_cmd_addr <= i_adr;
            o_cmd_num <= i_num;
        end
        else
        begin
            o_cmd_addr <= ~o_cmd_addr;
            o_cmd_num <= ~o_cmd_num;
        end
    end
endmodule : vam_host_model

/* bench/testbench.sv */
// self-checking bench for the valve alert monitor
`timescale 1ns/1ps
module testbench;
    import vam_pkg::*;
    localparam int unsigned PERS = 20;
    localparam logic [23:0] ID = 24'h5a5a5a; // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic [23:0] h_adr = 24'h0;
    logic [7:0] h_num = 8'h0;
    logic [7:0] rnd = 8'h55;
    vam_wb_req_t wb = '0;
    vam_sense_t sn;
    logic ack, rv, shut, fail, cv;
    logic [31:0] rdat, rsp;
    logic [23:0] ca;
    logic [7:0] cn;
    logic [63:0] q_rd[$];
    logic [63:0] q_rsp[$];
    logic [63:0] nt;
    logic [24:0] dc [8] = '{{1'b0, 8'h05, 8'h04, 8'h01},
        {1'b0, 8'h05, 8'h03, 8'h00}, {1'b0, 8'h5f, 8'h60, 8'h01},
        {1'b0, 8'h5f, 8'h61, 8'h00}, {1'b0, 8'h0a, 8'h32, 8'h00},
        {1'b1, 8'h05, 8'h60, 8'h01}, {1'b1, 8'h05, 8'h61, 8'h00},
        {1'b1, 8'h5f, 8'h04, 8'h01}};
    int bits [8] = '{10, 11, 12, 13, 16, 17, 19, 18};
    int n_errors = 0;
    int n_checks = 0;

    vam_top #(.DRV_PERSIST_CYC_P(PERS), .DEVICE_ID(ID)) uut (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_wb(wb), .o_wb_ack(ack),
        .o_wb_dat(rdat), .i_sense(sn), .i_cmd_valid(cv),
        .i_cmd_addr(ca), .i_cmd_num(cn), .o_rsp_valid(rv),
        .o_rsp_status(rsp), .o_shutdown(shut), .o_failure_any(fail));
    vam_host_model hm (.i_clk(clk), .i_rst(rst), .i_go(go),
        .i_adr(h_adr), .i_num(h_num), .o_cmd_valid(cv),
        .o_cmd_addr(ca), .o_cmd_num(cn));

    // free-running bench clock
    initial
    begin
        forever #25 clk = ~clk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic report_and_stop();
        if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic cmp(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic reset_dut();
        rst <= 1'b1;
        tick(10);
        rst <= 1'b0;
        tick(1);
    endtask : reset_dut

    // classic single cycle, held until ack is sampled
    task automatic wb_go(input logic w, input logic [7:0] a,
                         input logic [31:0] d);
        int n;
        n = 0;
        wb <= '{1'b1, 1'b1, w, a, 4'hf, d};
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        wb <= '0;
        tick(1);
        if (n >= 50)
        begin
            n_errors++;
            report_and_stop();
        end
    endtask : wb_go

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_go(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        q_rd.push_back({e & m, m});
        wb_go(1'b0, a, 32'h0);
    endtask : rd

    task automatic host(input logic [23:0] a, input logic [7:0] n,
                        input logic [31:0] e, input logic [31:0] m);
        if (a == ID && n == CMD_READ_STATUS)
            q_rsp.push_back({e & m, m});
        h_adr <= a;
        h_num <= n;
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(4);
    endtask : host

    task automatic set_one(input int i, input logic v);
        case (i)
            0: sn.cal <= v;
            1: sn.autocal <= v;
            2: sn.diag <= v;
            3: sn.diag_data <= v;
            4: sn.integ_hi <= v;
            5: sn.integ_lo <= v;
            6: sn.button_held <= v;
            default: sn.panel_link_ok <= ~v;
        endcase
    endtask : set_one

    // oldest note against each read answer and status answer
    always @(posedge clk)
    begin
        if (ack === 1'b1 && wb.we === 1'b0)
        begin
            nt = q_rd.size() ? q_rd.pop_front() : {32'hx, 32'hffffffff};
            cmp("wb read", nt[63:32], rdat & nt[31:0]);
        end
        if (rv === 1'b1)
        begin
            nt = q_rsp.size() ? q_rsp.pop_front() : {32'hx, 32'hffffffff};
            cmp("status answer", nt[63:32], rsp & nt[31:0]);
        end
    end

    // main sequence
    initial
    begin
        sn = '0;
        sn.panel_link_ok = 1'b1;
        sn.drive_pct = 8'h32;
        sn.travel_pct = 8'h32;
        reset_dut();
        rd(OFS_ALERT_EN, EN_RESET, '1);
        rd(OFS_SHUT_EN, SHUT_RESET, '1);
        rd(OFS_CYC_PT, {16'h0, CYC_PT_RESET}, '1);
        rd(OFS_DEV_ALLOW, {16'h0, DEV_ALLOW_RESET}, '1);
        wr(OFS_ALERT_EN, 32'h0);
        rd(OFS_ALERT_EN, FIXED_MASK, '1);
        wr(OFS_ALERT_EN, 32'hffffffff);
        rd(OFS_ACTIVE, 32'h8000, 32'h8000);
        wr(OFS_CTRL, 32'hc);
        rd(OFS_ACTIVE, 32'h0, 32'h8000);
        rd(8'h3c, 32'h0, '1);
        rd(OFS_REC_STAT, 32'h0, '1);
        // status alerts one at a time, panel mode on
        wr(OFS_CTRL, 32'h2);
        for (int i = 0; i < 8; i++)
        begin
            set_one(i, 1'b1);
            tick(4);
            rd(OFS_ACTIVE, 32'h1 << bits[i], 32'h1 << bits[i]);
            host(ID, CMD_READ_STATUS, 32'h100 | 1 << bits[i], '1 >> 9);
            host(ID ^ 24'h1, CMD_READ_STATUS, 0, 0);
            host(ID, 8'h31, 0, 0);
            set_one(i, 1'b0);
            tick(4);
            rd(OFS_ACTIVE, 32'h0, 32'h1 << bits[i]);
        end
        rd(OFS_REC_STAT, 32'h28, '1);
        wr(OFS_REC_IDX, 32'h0);
        rd(OFS_REC_DATA, 32'ha, '1);
        // overfill the record, then clear it
        repeat (14)
        begin
            sn.cal <= 1'b1;
            tick(3);
            sn.cal <= 1'b0;
            tick(3);
        end
        rd(OFS_REC_STAT, 32'h74, '1);
        rd(OFS_ACTIVE, 32'h300, 32'h300);
        wr(OFS_CTRL, 32'h4);
        rd(OFS_REC_STAT, 32'h0, '1);
        // disabled alert neither reported nor stored
        wr(OFS_ALERT_EN, 32'hfffffbff);
        sn.cal <= 1'b1;
        tick(4);
        rd(OFS_ACTIVE, 32'h0, 32'h400);
        host(ID, CMD_READ_STATUS, 32'h0, 32'h400);
        rd(OFS_REC_STAT, 32'h0, '1);
        sn.cal <= 1'b0;
        wr(OFS_ALERT_EN, 32'hffffffff);
        // cycle counter against its point
        wr(OFS_CYC_PT, 32'h3);
        for (int k = 0; k < 4; k++)
        begin
            sn.reversal <= 1'b1;
            tick(1);
            sn.reversal <= 1'b0;
            tick(3);
            rd(OFS_ACTIVE, {17'h0, k == 3, 14'h0}, 32'h4000);
        end
        wr(OFS_CYC_CNT, 32'h3);
        rd(OFS_ACTIVE, 32'h4000, 32'h4000);
        wr(OFS_CYC_CNT, 32'h9);
        wr(OFS_CYC_CNT, 32'h2);
        rd(OFS_ACTIVE, 32'h0, 32'h4000);
        rd(OFS_CYC_CNT, 32'h2, '1);
        // drive mismatch cases, both zero-power settings
        foreach (dc[i])
        begin
            wr(OFS_CTRL, {31'h0, dc[i][24]});
            sn.drive_pct <= dc[i][23:16];
            sn.travel_pct <= dc[i][15:8];
            tick(PERS - 8);
            rd(OFS_ACTIVE, 32'h0, 32'h400000);
            tick(12);
            rd(OFS_ACTIVE, {9'h0, dc[i][0], 22'h0}, 32'h400000);
            sn.drive_pct <= 8'h32;
            sn.travel_pct <= 8'h32;
            tick(4);
        end
        // pressure deviation at the allowance boundary
        sn.press_ctrl <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            rnd = lfsr(rnd);
            sn.press_sp <= {8'h10, rnd};
            sn.press <= {8'h10, rnd} + 16'h0100 + 16'(k % 2);
            tick(4);
            rd(OFS_ACTIVE, {11'h0, k % 2 == 1, 20'h0}, 32'h100000);
        end
        sn.press_ctrl <= 1'b0;
        tick(4);
        rd(OFS_ACTIVE, 32'h0, 32'h100000);
        // failure category and shutdown gating
        sn.hw_fault <= 8'h02;
        tick(4);
        cmp("failure", 32'h1, {31'h0, fail});
        cmp("shutdown", 32'h0, {31'h0, shut});
        wr(OFS_SHUT_EN, 32'hffffff02);
        rd(OFS_SHUT_EN, 32'h2, '1);
        tick(3);
        cmp("shutdown", 32'h1, {31'h0, shut});
        // latched failures survive until restart
        sn.hw_fault <= 8'h11;
        sn.loop_bad <= 1'b1;
        tick(3);
        sn.hw_fault <= 8'h00;
        sn.loop_bad <= 1'b0;
        tick(4);
        rd(OFS_ACTIVE, 32'h200011, 32'h200011);
        reset_dut();
        rd(OFS_ACTIVE, 32'h0, 32'h200011);
        if (q_rd.size() != 0 || q_rsp.size() != 0)
            n_errors++;
        report_and_stop();
    end
endmodule : testbench
